// *** charger_event_params.svh ***
// Constants of the charger event flag registers: offsets, bit positions.
// Included by the package and the design files; definitions only.
`ifndef CHARGER_EVENT_PARAMS_SVH
`define CHARGER_EVENT_PARAMS_SVH

// Register offsets
`define ADDR_INPUT_LIMIT_EVENTS   8'h0C
`define ADDR_DEVICE_EVENTS_TWO    8'h0D
`define ADDR_CHARGER_EVENTS       8'h0E
`define ADDR_THERMAL_EVENTS       8'h0F

// Flag reset value and read value of unmapped offsets
`define FLAGS_RESET               8'h00
`define UNMAPPED_READ             8'h00

// Input limit event register
`define BIT_INPUT_LIMIT           0

// Second device event register
`define BIT_BATTERY_PRESENCE      6
`define BIT_BYPASS_UVLO           4
`define BIT_SYSTEM_UVLO           3
`define BIT_CONVERTER_ILIM        2
`define BIT_CONVERTER_RUNAWAY     1
`define BIT_CONVERTER_PGOOD       0

// Charger event register
`define BIT_DIRECT_FAULT          7
`define BIT_LOW_POWER_RISE        6
`define BIT_LOW_POWER_FALL        5
`define BIT_CHARGER_STATE         4

// Thermal event register
`define BIT_THERMAL_CURRENT       6
`define BIT_THERMAL_VOLTAGE       5
`define BIT_THERMISTOR_STATE      4

// Widths of the multi-bit sources
`define CHARGER_STATE_W           4
`define THERMISTOR_STATE_W        3

`endif

// *** charger_event_pkg.sv ***
// Types shared by the charger event flag design files.
// Assumes charger_event_params.svh is on the include path.
package charger_event_pkg;
  `include "charger_event_params.svh"

  // One event register
  typedef logic [7:0] event_byte_t;

  // Register address
  typedef logic [7:0] reg_addr_t;

  // Snapshot of every watched status source
  typedef struct packed {
    logic                                input_limit;
    logic                                battery_presence_request;
    logic                                bypass_undervoltage_lockout;
    logic                                system_undervoltage_lockout;
    logic                                converter_current_limit;
    logic                                converter_runaway;
    logic                                converter_power_good;
    logic                                direct_charge_fault;
    logic                                low_power_status;
    logic [`CHARGER_STATE_W-1:0]         charger_state_field;
    logic                                thermal_current_reduction;
    logic                                thermal_voltage_reduction;
    logic [`THERMISTOR_STATE_W-1:0]      thermistor_temperature_state;
  } status_t;
endpackage

// *** flag_bank_if.sv ***
// Carrier between the register front end and one bank of event flags.
// Assumes both ends run on the same ref_clk.
`timescale 1ns/1ps
interface flag_bank_if;
  import charger_event_pkg::*;
  event_byte_t set_bits;  // Flags to set this cycle
  logic        clear;     // Register is being read
  event_byte_t flags;     // Current flag state

  modport owner (output set_bits, output clear, input flags);
  modport bank  (input set_bits, input clear, output flags);
endinterface

// *** event_flag_bank.sv ***
// One clear-on-read register of sticky event flags.
// Assumes set bits arrive already masked to the implemented positions.
`timescale 1ns/1ps
`include "charger_event_params.svh"
module event_flag_bank
  import charger_event_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  flag_bank_if.bank port
);

  // Sticky flags; a set in the clearing cycle survives the clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      port.flags <= `FLAGS_RESET;
    end else begin
      port.flags <= (port.flags & ~{8{port.clear}}) | port.set_bits;
    end
  end

  set_wins_a: assert property (@(posedge ref_clk) disable iff (rst)
    (port.set_bits != 8'h00) |=> ((port.flags & $past(port.set_bits)) == $past(port.set_bits)))
    else $error("set bit lost in flag bank");

  clear_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    port.clear |=> (port.flags == $past(port.set_bits)))
    else $error("read did not clear flag bank");

  hold_flags_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!port.clear && port.set_bits == 8'h00) |=> $stable(port.flags))
    else $error("flags changed without cause");

endmodule

// *** charger_event_flag_registers.sv ***
// Four clear-on-read event flag registers of the charger, 0x0C to 0x0F.
// Assumes status inputs are synchronous to ref_clk; strobes one cycle long.
//
// Operation
// - Input limit change flag at 0x0C
// - Device register 0x0D, bits 7,5 unused
// - Flag set on change, read clears
// - Bit 6: battery presence request change
// - Bit 4: bypass undervoltage change
// - Bit 1: converter runaway change
// - Bit 0: converter power good change
// - Charger event register at 0x0E
// - Bit 7: direct charge fault change
// - Separate low power rise, fall flags
// - Thermal register at 0x0F, bits 7,3-0 unused
// - Thermal current reduction change flag
// - Thermal voltage reduction change flag
// - Flag on any thermistor state change
`timescale 1ns/1ps
`include "charger_event_params.svh"
module charger_event_flag_registers
  import charger_event_pkg::*;
(
  input  wire logic                           ref_clk,
  input  wire logic                           rst,
  input  wire logic [7:0]                     addr,
  input  wire logic [7:0]                     wr_data,
  input  wire logic                           wr_en,
  input  wire logic                           rd_en,
  output      logic [7:0]                     rd_data,
  input  wire logic                           input_limit,
  input  wire logic                           battery_presence_request,
  input  wire logic                           bypass_undervoltage_lockout,
  input  wire logic                           system_undervoltage_lockout,
  input  wire logic                           converter_current_limit,
  input  wire logic                           converter_runaway,
  input  wire logic                           converter_power_good,
  input  wire logic                           direct_charge_fault,
  input  wire logic                           low_power_status,
  input  wire logic [`CHARGER_STATE_W-1:0]    charger_state_field,
  input  wire logic                           thermal_current_reduction,
  input  wire logic                           thermal_voltage_reduction,
  input  wire logic [`THERMISTOR_STATE_W-1:0] thermistor_temperature_state
);

  // Any bit of a field differs from its last sample
  function automatic logic changed(input logic [3:0] now_v, input logic [3:0] last_v);
    changed = (now_v != last_v);
  endfunction

  status_t     status_now;    // Present status sources
  status_t     status_last;   // Status one cycle ago
  logic        primed;        // Last sample is valid
  event_byte_t il_set;        // Sets for 0x0C
  event_byte_t dev_set;       // Sets for 0x0D
  event_byte_t chg_set;       // Sets for 0x0E
  event_byte_t thm_set;       // Sets for 0x0F

  flag_bank_if il_if ();
  flag_bank_if dev_if ();
  flag_bank_if chg_if ();
  flag_bank_if thm_if ();

  // Gather the sources into one snapshot
  always_comb begin
    status_now.input_limit                  = input_limit;
    status_now.battery_presence_request     = battery_presence_request;
    status_now.bypass_undervoltage_lockout  = bypass_undervoltage_lockout;
    status_now.system_undervoltage_lockout  = system_undervoltage_lockout;
    status_now.converter_current_limit      = converter_current_limit;
    status_now.converter_runaway            = converter_runaway;
    status_now.converter_power_good         = converter_power_good;
    status_now.direct_charge_fault          = direct_charge_fault;
    status_now.low_power_status             = low_power_status;
    status_now.charger_state_field          = charger_state_field;
    status_now.thermal_current_reduction    = thermal_current_reduction;
    status_now.thermal_voltage_reduction    = thermal_voltage_reduction;
    status_now.thermistor_temperature_state = thermistor_temperature_state;
  end

  // Previous sample; reset takes a constant, so the first cycle only primes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_last <= '0;
    end else begin
      status_last <= status_now;
    end
  end

  // Avoids a spurious event from the reset value of the last sample
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      primed <= 1'b0;
    end else begin
      primed <= 1'b1;
    end
  end

  // Change detection per flag; unused positions stay zero
  always_comb begin
    il_set  = `FLAGS_RESET;
    dev_set = `FLAGS_RESET;
    chg_set = `FLAGS_RESET;
    thm_set = `FLAGS_RESET;
    if (primed) begin
      il_set[`BIT_INPUT_LIMIT] = changed({3'h0, status_now.input_limit},
                                         {3'h0, status_last.input_limit});
      dev_set[`BIT_BATTERY_PRESENCE] = changed({3'h0, status_now.battery_presence_request},
                                               {3'h0, status_last.battery_presence_request});
      dev_set[`BIT_BYPASS_UVLO] = changed({3'h0, status_now.bypass_undervoltage_lockout},
                                          {3'h0, status_last.bypass_undervoltage_lockout});
      dev_set[`BIT_SYSTEM_UVLO] = changed({3'h0, status_now.system_undervoltage_lockout},
                                          {3'h0, status_last.system_undervoltage_lockout});
      dev_set[`BIT_CONVERTER_ILIM] = changed({3'h0, status_now.converter_current_limit},
                                             {3'h0, status_last.converter_current_limit});
      dev_set[`BIT_CONVERTER_RUNAWAY] = changed({3'h0, status_now.converter_runaway},
                                                {3'h0, status_last.converter_runaway});
      dev_set[`BIT_CONVERTER_PGOOD] = changed({3'h0, status_now.converter_power_good},
                                              {3'h0, status_last.converter_power_good});
      chg_set[`BIT_DIRECT_FAULT] = changed({3'h0, status_now.direct_charge_fault},
                                           {3'h0, status_last.direct_charge_fault});
      chg_set[`BIT_LOW_POWER_RISE] = status_now.low_power_status & ~status_last.low_power_status;
      chg_set[`BIT_LOW_POWER_FALL] = ~status_now.low_power_status & status_last.low_power_status;
      chg_set[`BIT_CHARGER_STATE] = changed(status_now.charger_state_field,
                                            status_last.charger_state_field);
      thm_set[`BIT_THERMAL_CURRENT] = changed({3'h0, status_now.thermal_current_reduction},
                                              {3'h0, status_last.thermal_current_reduction});
      thm_set[`BIT_THERMAL_VOLTAGE] = changed({3'h0, status_now.thermal_voltage_reduction},
                                              {3'h0, status_last.thermal_voltage_reduction});
      thm_set[`BIT_THERMISTOR_STATE] = changed({1'b0, status_now.thermistor_temperature_state},
                                               {1'b0, status_last.thermistor_temperature_state});
    end
  end

  // Feed the banks; a read of a register clears the flags it returns
  always_comb begin
    il_if.set_bits  = il_set;
    dev_if.set_bits = dev_set;
    chg_if.set_bits = chg_set;
    thm_if.set_bits = thm_set;
    il_if.clear  = rd_en && (addr == `ADDR_INPUT_LIMIT_EVENTS);
    dev_if.clear = rd_en && (addr == `ADDR_DEVICE_EVENTS_TWO);
    chg_if.clear = rd_en && (addr == `ADDR_CHARGER_EVENTS);
    thm_if.clear = rd_en && (addr == `ADDR_THERMAL_EVENTS);
  end

  event_flag_bank il_bank  (.ref_clk(ref_clk), .rst(rst), .port(il_if.bank));
  event_flag_bank dev_bank (.ref_clk(ref_clk), .rst(rst), .port(dev_if.bank));
  event_flag_bank chg_bank (.ref_clk(ref_clk), .rst(rst), .port(chg_if.bank));
  event_flag_bank thm_bank (.ref_clk(ref_clk), .rst(rst), .port(thm_if.bank));

  // Read data register; zero outside a read so stale flags never linger
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data <= `UNMAPPED_READ;
    end else if (!rd_en) begin
      rd_data <= `UNMAPPED_READ;
    end else if (addr == `ADDR_INPUT_LIMIT_EVENTS) begin
      rd_data <= il_if.flags;
    end else if (addr == `ADDR_DEVICE_EVENTS_TWO) begin
      rd_data <= dev_if.flags;
    end else if (addr == `ADDR_CHARGER_EVENTS) begin
      rd_data <= chg_if.flags;
    end else if (addr == `ADDR_THERMAL_EVENTS) begin
      rd_data <= thm_if.flags;
    end else begin
      rd_data <= `UNMAPPED_READ;
    end
  end

  // Writes have no target: every flag is read-only, so wr_data is ignored
  logic write_seen;  // Helper for the write check
  assign write_seen = wr_en & (|wr_data | ~(|wr_data));

  // Read returns the flags held at the strobe
  read_returns_a: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_en && addr == `ADDR_CHARGER_EVENTS) |=> (rd_data == $past(chg_if.flags)))
    else $error("charger register read wrong");

  // Unimplemented positions never hold a flag
  unused_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    (il_if.flags[7:1] == 7'h00) && !dev_if.flags[7] && !dev_if.flags[5]
    && (chg_if.flags[3:0] == 4'h0) && !thm_if.flags[7] && (thm_if.flags[3:0] == 4'h0))
    else $error("unused flag bit set");

  // A write strobe has no path into any flag
  write_ignored_a: assert property (@(posedge ref_clk) disable iff (rst)
    (write_seen && !rd_en && il_set == 8'h00) |=> $stable(il_if.flags))
    else $error("write altered a flag");

  // Input limit change raises its flag one edge later
  input_change_a: assert property (@(posedge ref_clk) disable iff (rst)
    ($past(primed) && $changed(input_limit)) |=> il_if.flags[`BIT_INPUT_LIMIT])
    else $error("input limit change not flagged");

  // Rising low power edge sets only the rise flag
  rise_only_a: assert property (@(posedge ref_clk) disable iff (rst)
    (primed && $rose(low_power_status)) |=> (chg_if.flags[`BIT_LOW_POWER_RISE]
    && chg_if.flags[`BIT_LOW_POWER_FALL] == ($past(chg_if.flags[`BIT_LOW_POWER_FALL]) && !$past(chg_if.clear))))
    else $error("low power rise mishandled");

  // Falling low power edge sets only the fall flag
  fall_only_a: assert property (@(posedge ref_clk) disable iff (rst)
    (primed && $fell(low_power_status)) |=> (chg_if.flags[`BIT_LOW_POWER_FALL]
    && chg_if.flags[`BIT_LOW_POWER_RISE] == ($past(chg_if.flags[`BIT_LOW_POWER_RISE]) && !$past(chg_if.clear))))
    else $error("low power fall mishandled");

  // Any charger state bit change raises one flag
  state_change_a: assert property (@(posedge ref_clk) disable iff (rst)
    (primed && $changed(charger_state_field)) |=> chg_if.flags[`BIT_CHARGER_STATE])
    else $error("charger state change lost");

  // Change, one quiet cycle, then a read: the read must report it
  thermistor_change_a: assert property (@(posedge ref_clk) disable iff (rst)
    (primed && $changed(thermistor_temperature_state)) ##1 !(rd_en && addr == `ADDR_THERMAL_EVENTS)
    ##1 (rd_en && addr == `ADDR_THERMAL_EVENTS) |=> rd_data[`BIT_THERMISTOR_STATE])
    else $error("thermistor change not read");

  // Converter runaway change raises its flag
  runaway_change_a: assert property (@(posedge ref_clk) disable iff (rst)
    (primed && $changed(converter_runaway)) |=> dev_if.flags[`BIT_CONVERTER_RUNAWAY])
    else $error("runaway change not flagged");

  // Presence request change raises its flag
  presence_change_a: assert property (@(posedge ref_clk) disable iff (rst)
    (primed && $changed(battery_presence_request)) |=> dev_if.flags[`BIT_BATTERY_PRESENCE])
    else $error("presence change not flagged");

  // Bypass lockout change raises its flag
  bypass_change_a: assert property (@(posedge ref_clk) disable iff (rst)
    (primed && $changed(bypass_undervoltage_lockout)) |=> dev_if.flags[`BIT_BYPASS_UVLO])
    else $error("bypass lockout change not flagged");

  // System lockout change raises its flag
  system_change_a: assert property (@(posedge ref_clk) disable iff (rst)
    (primed && $changed(system_undervoltage_lockout)) |=> dev_if.flags[`BIT_SYSTEM_UVLO])
    else $error("system lockout change not flagged");

  // Converter current limit change raises its flag
  ilim_change_a: assert property (@(posedge ref_clk) disable iff (rst)
    (primed && $changed(converter_current_limit)) |=> dev_if.flags[`BIT_CONVERTER_ILIM])
    else $error("converter limit change not flagged");

  // Power good change raises its flag
  pgood_change_a: assert property (@(posedge ref_clk) disable iff (rst)
    (primed && $changed(converter_power_good)) |=> dev_if.flags[`BIT_CONVERTER_PGOOD])
    else $error("power good change not flagged");

  // Direct charge fault change raises its flag
  fault_change_a: assert property (@(posedge ref_clk) disable iff (rst)
    (primed && $changed(direct_charge_fault)) |=> chg_if.flags[`BIT_DIRECT_FAULT])
    else $error("direct fault change not flagged");

  // Thermal current reduction change raises its flag
  thermal_current_a: assert property (@(posedge ref_clk) disable iff (rst)
    (primed && $changed(thermal_current_reduction)) |=> thm_if.flags[`BIT_THERMAL_CURRENT])
    else $error("thermal current change not flagged");

  // Thermal voltage reduction change raises its flag
  thermal_voltage_a: assert property (@(posedge ref_clk) disable iff (rst)
    (primed && $changed(thermal_voltage_reduction)) |=> thm_if.flags[`BIT_THERMAL_VOLTAGE])
    else $error("thermal voltage change not flagged");

  // Read data stand one cycle only, then drop to zero
  idle_read_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    !rd_en |=> (rd_data == 8'h00))
    else $error("read data outside a read");

  // Unmapped offsets read zero, so software may probe them safely
  unmapped_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_en && addr != `ADDR_INPUT_LIMIT_EVENTS && addr != `ADDR_DEVICE_EVENTS_TWO
    && addr != `ADDR_CHARGER_EVENTS && addr != `ADDR_THERMAL_EVENTS) |=> (rd_data == `UNMAPPED_READ))
    else $error("unmapped read not zero");

  // Main scenarios: flagged read, clash, fall edge, thermistor read, back-to-back reads
  read_set_cover: cover property (@(posedge ref_clk) disable iff (rst)
    (rd_en && addr == `ADDR_DEVICE_EVENTS_TWO) ##1 (rd_data != 8'h00));
  clash_cover: cover property (@(posedge ref_clk) disable iff (rst)
    il_if.clear && il_set != 8'h00);
  fall_cover: cover property (@(posedge ref_clk) disable iff (rst)
    chg_set[`BIT_LOW_POWER_FALL]);
  thermistor_read_cover: cover property (@(posedge ref_clk) disable iff (rst)
    (rd_en && addr == `ADDR_THERMAL_EVENTS) ##1 rd_data[`BIT_THERMISTOR_STATE]);
  back_to_back_cover: cover property (@(posedge ref_clk) disable iff (rst)
    rd_en ##1 rd_en);

endmodule

// *** test_charger_event_flag_registers.sv ***
// Self-checking bench for the four clear-on-read charger event flag registers.
// Assumes the design package and its constants header are compiled first.
`timescale 1ns/1ps
`include "charger_event_params.svh"
module test_charger_event_flag_registers
  import charger_event_pkg::*;
;

  logic        ref_clk;      // 25 MHz bench clock
  logic        rst;          // Async reset, active high
  reg_addr_t   addr;         // Register address
  event_byte_t wr_data;      // Write data, must be ignored
  logic        wr_en;        // Write strobe
  logic        rd_en;        // Read strobe
  event_byte_t rd_data;      // Read data, one cycle after rd_en
  logic [17:0] st_v;         // All status sources, flat
  int          bad_count;    // Mismatches seen
  int          check_count;  // Comparisons made

  charger_event_flag_registers dut_u (
    .ref_clk                      (ref_clk),
    .rst                          (rst),
    .addr                         (addr),
    .wr_data                      (wr_data),
    .wr_en                        (wr_en),
    .rd_en                        (rd_en),
    .rd_data                      (rd_data),
    .input_limit                  (st_v[17]),
    .battery_presence_request     (st_v[16]),
    .bypass_undervoltage_lockout  (st_v[15]),
    .system_undervoltage_lockout  (st_v[14]),
    .converter_current_limit      (st_v[13]),
    .converter_runaway            (st_v[12]),
    .converter_power_good         (st_v[11]),
    .direct_charge_fault          (st_v[10]),
    .low_power_status             (st_v[9]),
    .charger_state_field          (st_v[8:5]),
    .thermal_current_reduction    (st_v[4]),
    .thermal_voltage_reduction    (st_v[3]),
    .thermistor_temperature_state (st_v[2:0])
  );

  // Clock: 40 ns period
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Verdict and end of run, shared with the watchdog
  task automatic end_sim();
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Compare seen against expected; four-state so X never matches
  task automatic chk(input string what, input event_byte_t seen, input event_byte_t exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One read cycle; data sampled mid-cycle after the taking edge
  task automatic rd(input reg_addr_t a, input event_byte_t exp);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(negedge ref_clk);
    chk($sformatf("read_%h", a), rd_data, exp);
  endtask

  // One write cycle; has no effect on any flag
  task automatic wr(input reg_addr_t a, input event_byte_t d);
    @(posedge ref_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  // Flip one status bit, presented for one cycle before any read
  task automatic tog(input int i);
    @(posedge ref_clk);
    st_v[i] <= ~st_v[i];
  endtask

  // Source bit to {register, flag mask}; every bit of a field maps to one flag
  function automatic logic [15:0] src_map(input int i);
    case (i)
      17:         src_map = {`ADDR_INPUT_LIMIT_EVENTS, 8'h01 << `BIT_INPUT_LIMIT};
      16:         src_map = {`ADDR_DEVICE_EVENTS_TWO, 8'h01 << `BIT_BATTERY_PRESENCE};
      15:         src_map = {`ADDR_DEVICE_EVENTS_TWO, 8'h01 << `BIT_BYPASS_UVLO};
      14:         src_map = {`ADDR_DEVICE_EVENTS_TWO, 8'h01 << `BIT_SYSTEM_UVLO};
      13:         src_map = {`ADDR_DEVICE_EVENTS_TWO, 8'h01 << `BIT_CONVERTER_ILIM};
      12:         src_map = {`ADDR_DEVICE_EVENTS_TWO, 8'h01 << `BIT_CONVERTER_RUNAWAY};
      11:         src_map = {`ADDR_DEVICE_EVENTS_TWO, 8'h01 << `BIT_CONVERTER_PGOOD};
      10:         src_map = {`ADDR_CHARGER_EVENTS, 8'h01 << `BIT_DIRECT_FAULT};
      8, 7, 6, 5: src_map = {`ADDR_CHARGER_EVENTS, 8'h01 << `BIT_CHARGER_STATE};
      4:          src_map = {`ADDR_THERMAL_EVENTS, 8'h01 << `BIT_THERMAL_CURRENT};
      3:          src_map = {`ADDR_THERMAL_EVENTS, 8'h01 << `BIT_THERMAL_VOLTAGE};
      default:    src_map = {`ADDR_THERMAL_EVENTS, 8'h01 << `BIT_THERMISTOR_STATE};
    endcase
  endfunction

  // Watchdog: the sequence needs well under 1500 cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    end_sim();
  end

  // Main sequence
  initial begin
    logic [15:0] m;
    rst         = 1'b1;
    addr        = 8'h00;
    wr_data     = 8'h00;
    wr_en       = 1'b0;
    rd_en       = 1'b0;
    st_v        = '0;
    bad_count   = 0;
    check_count = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    // Each source but low power, both directions; read clears, unused bits stay zero
    for (int i = 0; i < 18; i++) begin
      if (i != 9) begin
        m = src_map(i);
        tog(i);
        rd(m[15:8], m[7:0]);
        rd(m[15:8], 8'h00);
        tog(i);
        rd(m[15:8], m[7:0]);
      end
    end
    // Low power edges land in separate flags
    tog(9);
    rd(`ADDR_CHARGER_EVENTS, 8'h01 << `BIT_LOW_POWER_RISE);
    tog(9);
    rd(`ADDR_CHARGER_EVENTS, 8'h01 << `BIT_LOW_POWER_FALL);
    // Unmapped reads and all writes leave a pending flag alone
    tog(17);
    rd(8'h10, 8'h00);
    rd(8'h0B, 8'h00);
    wr(`ADDR_INPUT_LIMIT_EVENTS, 8'h00);
    wr(`ADDR_THERMAL_EVENTS, 8'hFF);
    rd(`ADDR_THERMAL_EVENTS, 8'h00);
    // Change in the same cycle as the clearing read survives it
    @(posedge ref_clk);
    addr     <= `ADDR_INPUT_LIMIT_EVENTS;
    rd_en    <= 1'b1;
    st_v[17] <= ~st_v[17];
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(negedge ref_clk);
    chk("same_cycle_read", rd_data, 8'h01);
    rd(`ADDR_INPUT_LIMIT_EVENTS, 8'h01);
    // Back-to-back reads, data stands one cycle only
    tog(10);
    tog(17);
    @(posedge ref_clk);
    addr  <= `ADDR_INPUT_LIMIT_EVENTS;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    addr <= `ADDR_CHARGER_EVENTS;
    @(negedge ref_clk);
    chk("b2b_first", rd_data, 8'h01);
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(negedge ref_clk);
    chk("b2b_second", rd_data, 8'h80);
    @(negedge ref_clk);
    chk("idle_data", rd_data, 8'h00);
    // Mid-run reset: flags drop, status held during reset primes only
    tog(16);
    @(posedge ref_clk);
    rst  <= 1'b1;
    st_v <= 18'h3FFFF;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`ADDR_INPUT_LIMIT_EVENTS, 8'h00);
    rd(`ADDR_DEVICE_EVENTS_TWO, 8'h00);
    rd(`ADDR_CHARGER_EVENTS, 8'h00);
    rd(`ADDR_THERMAL_EVENTS, 8'h00);
    end_sim();
  end
endmodule
